// File: hdl/column_scan_pkg.sv
// Constants for the dot matrix column scan controller.
// Assumes a single 100 MHz clock domain and a synchronous active-high reset.
// Summary of operation
// RULE1 - Twenty-eight 5x7 characters in seven chips.
// RULE2 - Five columns; each column has one shared driver. The code has shared driver outputs for the first and fifth columns only.
// RULE3 - Row bit one pulls row cathodes low.
// RULE4 - One column lit about 2.5 ms.
// RULE5 - Full five-column scan about 80 per second.
// RULE6 - Load from last character toward first.
// RULE7 - Seven-bit pattern loaded parallel, shifted serially.
// RULE8 - Column load ends after 196 shifted bits.
// RULE9 - Selected column line driven high to light.
// RULE10 - Load and enable repeated for all columns.
// RULE11 - Serial shift timed by dot shift clock.
// RULE12 - Column enabled by writing low control bit.
// RULE13 - All column drivers off during shifting.
`default_nettype none
package column_scan_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int CHARS = 28;
  localparam int CHIPS = 7;
  localparam int COLUMNS = 5;
  localparam int ROWS = 7;
  localparam int BITS_PER_COLUMN = ROWS * CHARS;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int COLUMN_TIME_US = 2500;
  localparam int COLUMN_CYCLES = COLUMN_TIME_US * (CLK_HZ / 1_000_000);
  localparam int REFRESH_HZ = 80;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] COLUMN_RESET = 3'h0;
  localparam logic [4:0] CHAR_RESET = 5'h1b;
  localparam logic [4:0] COLUMN_OFF_N = 5'h1f;

  typedef enum logic [1:0] {
    st_fetch = 2'b00,
    st_shift = 2'b01,
    st_light = 2'b11
  } scan_state_t;

endpackage : column_scan_pkg
`default_nettype wire

// File: hdl/dot_matrix_column_scan.sv
// Column scan controller for a 28-character 5x7 dot matrix display.
// Assumes the display processor supplies the dot shift clock on a pin and
// answers pattern lookups combinationally on the same clock as this block.
`timescale 1ns/1ps
`default_nettype none

module dot_matrix_column_scan #(
  parameter int CHARS = 28,
  parameter int ROWS = 7,
  parameter int COLUMNS = 5,
  parameter int COLUMN_CYCLES = column_scan_pkg::COLUMN_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic dot_shift_clk,
  output logic [4:0] char_index,
  output logic [2:0] column_index,
  input wire logic [6:0] row_pattern,
  output logic row_data,
  output logic row_shift,
  output logic [4:0] column_select_n,
  output logic column_select_first,
  output logic column_select_fifth,
  output logic [4:0] column_line,
  output logic load_done
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (CHARS != 28 || ROWS != 7 || COLUMNS != 5) begin : g_bad_geometry // see RULE1
    $error("Only the 28 by 5x7 geometry is supported.");
  end
  if (COLUMN_CYCLES < 1) begin : g_bad_time
    $error("COLUMN_CYCLES must be at least one.");
  end

  // ----------------------------------------------------------------------
  // Shift clock synchroniser and edge finder
  // ----------------------------------------------------------------------
  logic sclk_meta;
  logic sclk_sync;
  logic sclk_prev;
  logic sclk_rise;

  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
    end else if (clk_en) begin
      sclk_meta <= dot_shift_clk;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
    end
  end

  assign sclk_rise = sclk_sync & ~sclk_prev; // see RULE11

  // ----------------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------------
  column_scan_pkg::scan_state_t state;
  logic [6:0] shreg;
  logic [2:0] bit_count;
  logic [7:0] shifted;
  logic [31:0] light_count;

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= column_scan_pkg::st_fetch;
    end else if (clk_en) begin
      unique case (state)
        column_scan_pkg::st_fetch: begin
          state <= column_scan_pkg::st_shift;
        end
        column_scan_pkg::st_shift: begin
          if (sclk_rise && shifted == 8'(CHARS * ROWS - 1)) begin
            state <= column_scan_pkg::st_light; // see RULE8
          end else if (sclk_rise && bit_count == 3'h6) begin
            state <= column_scan_pkg::st_fetch;
          end
        end
        column_scan_pkg::st_light: begin
          if (light_count == 32'(COLUMN_CYCLES - 1)) begin
            state <= column_scan_pkg::st_fetch; // see RULE4
          end
        end
        default: begin
          state <= column_scan_pkg::st_fetch;
        end
      endcase
    end
  end

  // Character walks from the last position toward the first.
  always_ff @(posedge clk) begin
    if (reset) begin
      char_index <= column_scan_pkg::CHAR_RESET;
    end else if (clk_en) begin
      if (state == column_scan_pkg::st_shift && sclk_rise && bit_count == 3'h6) begin
        if (char_index == 5'h00) begin
          char_index <= column_scan_pkg::CHAR_RESET; // see RULE6
        end else begin
          char_index <= char_index - 5'h01; // see RULE6
        end
      end
    end
  end

  // Column advances after each lit period and wraps after the fifth.
  always_ff @(posedge clk) begin
    if (reset) begin
      column_index <= column_scan_pkg::COLUMN_RESET;
    end else if (clk_en) begin
      if (state == column_scan_pkg::st_light && light_count == 32'(COLUMN_CYCLES - 1)) begin
        if (column_index == 3'h4) begin
          column_index <= column_scan_pkg::COLUMN_RESET; // see RULE10
        end else begin
          column_index <= column_index + 3'h1; // see RULE10
        end
      end
    end
  end

  // Parallel load of the seven row bits, then serial shift out.
  always_ff @(posedge clk) begin
    if (reset) begin
      shreg <= 7'h00;
      bit_count <= 3'h0;
      row_data <= 1'b0;
    end else if (clk_en) begin
      if (state == column_scan_pkg::st_fetch) begin
        shreg <= row_pattern; // see RULE7
        bit_count <= 3'h0;
        row_data <= row_pattern[6];
      end else if (state == column_scan_pkg::st_shift && sclk_rise) begin
        shreg <= {shreg[5:0], 1'b0}; // see RULE7
        bit_count <= bit_count + 3'h1;
        row_data <= shreg[5]; // see RULE3
      end
    end
  end

  // Count of bits shifted into the chain for the current column.
  always_ff @(posedge clk) begin
    if (reset) begin
      shifted <= 8'h00;
    end else if (clk_en) begin
      if (state == column_scan_pkg::st_light) begin
        shifted <= 8'h00;
      end else if (state == column_scan_pkg::st_shift && sclk_rise) begin
        shifted <= shifted + 8'h01; // see RULE8
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      light_count <= 32'h0000_0000;
    end else if (clk_en) begin
      if (state == column_scan_pkg::st_light) begin
        light_count <= light_count + 32'h0000_0001; // see RULE5
      end else begin
        light_count <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Column drivers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      column_select_n <= column_scan_pkg::COLUMN_OFF_N;
      column_line <= 5'h00;
      load_done <= 1'b0;
    end else if (clk_en) begin
      if (state == column_scan_pkg::st_light) begin
        column_select_n <= ~(5'h01 << column_index); // see RULE12
        column_line <= 5'h01 << column_index; // see RULE9
        load_done <= 1'b1;
      end else begin
        column_select_n <= column_scan_pkg::COLUMN_OFF_N; // see RULE13
        column_line <= 5'h00; // see RULE2
        load_done <= 1'b0;
      end
    end
  end

  // Gated by the clock enable so a frozen edge is not taken twice downstream.
  assign row_shift = clk_en & (state == column_scan_pkg::st_shift) & sclk_rise; // see RULE11
  assign column_select_first = column_line[0];
  assign column_select_fifth = column_line[4];

endmodule : dot_matrix_column_scan
`default_nettype wire

// File: bench/led_chain.sv
// Model of the display chip chain fed by the row shift path.
// Assumes it runs on the controller clock and sees its serial pins.
`timescale 1ns/1ps
`default_nettype none
module led_chain (
  input wire logic clk,
  input wire logic row_shift,
  input wire logic row_data,
  output logic [195:0] dots
);
  // Each shift pulse moves the chain one place and takes one row bit.
  always_ff @(posedge clk) begin
    if (row_shift) begin
      dots <= {dots[194:0], row_data};
    end
  end
endmodule : led_chain
`default_nettype wire

// File: bench/column_scan_asserts.sv
// Checker for the column scan controller ports.
// Assumes a bind to every instance of the controller.
`timescale 1ns/1ps
`default_nettype none
module column_scan_asserts #(
  parameter int COLUMN_CYCLES = 50
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic dot_shift_clk,
  input wire logic [4:0] char_index,
  input wire logic row_shift,
  input wire logic [4:0] column_select_n,
  input wire logic column_select_first,
  input wire logic column_select_fifth,
  input wire logic [4:0] column_line,
  input wire logic load_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  int bits;
  int lit;
  logic [4:0] prev;
  always_ff @(posedge clk) begin
    bits <= (reset || load_done) ? 0 : bits + int'(row_shift);
  end
  always_ff @(posedge clk) begin
    lit <= load_done ? lit + 1 : 0;
  end
  always_ff @(posedge clk) begin
    prev <= reset ? 5'h00 : ($rose(load_done) ? column_line : prev);
  end
  property p_lit; load_done |-> $onehot(column_line); endproperty
  a_lit: assert property (p_lit) else $error("lit columns not one");
  property p_dark; !load_done |-> column_line == 5'h00; endproperty
  a_dark: assert property (p_dark) else $error("column lit while loading");
  property p_latch; column_select_n == ~column_line; endproperty
  a_latch: assert property (p_latch) else $error("latch bits wrong");
  property p_ends; column_select_first == column_line[0] && column_select_fifth == column_line[4]; endproperty
  a_ends: assert property (p_ends) else $error("shared drivers wrong");
  property p_dwell; $fell(load_done) |-> lit == COLUMN_CYCLES; endproperty
  a_dwell: assert property (p_dwell) else $error("lit time wrong");
  property p_count; $rose(load_done) |-> bits == 196; endproperty
  a_count: assert property (p_count) else $error("bit count wrong");
  property p_next; $rose(load_done) && prev != 5'h00 |-> column_line == {prev[3:0], prev[4]}; endproperty
  a_next: assert property (p_next) else $error("column order wrong");
  property p_down; $changed(char_index) |-> char_index == $past(char_index) - 5'h01 || char_index == 5'h1b; endproperty
  a_down: assert property (p_down) else $error("character order wrong");
  property p_sync; row_shift |-> $past(dot_shift_clk, 2) ##1 !row_shift; endproperty
  a_sync: assert property (p_sync) else $error("shift without clock");
  c_light: cover property ($rose(load_done));
  c_fifth: cover property (column_select_fifth);
  c_wrap: cover property (column_select_fifth ##1 !load_done);
endmodule : column_scan_asserts
bind dot_matrix_column_scan column_scan_asserts #(.COLUMN_CYCLES(COLUMN_CYCLES)) u_chk (
  .clk(clk),
  .reset(reset),
  .dot_shift_clk(dot_shift_clk),
  .char_index(char_index),
  .row_shift(row_shift),
  .column_select_n(column_select_n),
  .column_select_first(column_select_first),
  .column_select_fifth(column_select_fifth),
  .column_line(column_line),
  .load_done(load_done)
);
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the column scan controller.
// Assumes the package, the design, the chain model and the checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module testbench;
  logic clk = 0, reset = 1, sclk = 0;
  logic [4:0] char_index, column_select_n, column_line;
  logic [2:0] column_index;
  logic row_data, row_shift, load_done;
  logic [195:0] dots;
  logic [6:0] pat [28][5];
  logic [205:0] notes [$];
  logic [205:0] exp;
  logic [205:0] note;
  logic [31:0] seed = 32'hbc47_5636;
  int n_mismatch = 0, comparisons = 0;
  always #5 clk = ~clk;
  initial begin
    #3.3;
    forever #62.5 sclk = ~sclk;
  end
  dot_matrix_column_scan #(.COLUMN_CYCLES(20)) dut (.clk(clk), .reset(reset), .clk_en(1'b1),
    .dot_shift_clk(sclk), .char_index(char_index), .column_index(column_index),
    .row_pattern(pat[char_index][column_index]), .row_data(row_data), .row_shift(row_shift),
    .column_select_n(column_select_n), .column_select_first(), .column_select_fifth(),
    .column_line(column_line), .load_done(load_done));
  led_chain chain (.clk(clk), .row_shift(row_shift), .row_data(row_data), .dots(dots));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic test_done;
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  initial begin
    for (int ch = 0; ch < 28; ch++)
      for (int c = 0; c < 5; c++) begin
        seed = xs(seed);
        pat[ch][c] = seed[6:0];
      end
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 5; c++) begin
        exp = '0;
        for (int ch = 27; ch >= 0; ch--) exp[195:0] = {exp[188:0], pat[ch][c]};
        exp[200:196] = 5'h01 << c;
        exp[205:201] = ~(5'h01 << c);
        notes.push_back(exp);
      end
    repeat (5) @(posedge clk);
    #1;
    `CHK({column_select_n, column_line, char_index}, {5'h1f, 5'h00, 5'h1b})
    reset = 0;
    repeat (10) @(negedge load_done);
    test_done();
  end
  always @(posedge load_done) begin
    #1;
    note = notes.pop_front();
    `CHK({column_select_n, column_line, dots}, note)
    $display("column %0d done", column_index);
  end
  initial begin
    #600000;
    n_mismatch++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
